// [core/droop_pkg.sv]
/*
 Constants for the supply droop detector control block: register offsets,
 field positions, reset values and settle timing. Assumes a 10 MHz clock.
*/
package droop_pkg;
	localparam int          CLK_PERIOD_NS   = 100;
	localparam logic [11:0] OFS_LV_CTRL     = 12'h000;
	localparam logic [11:0] OFS_CORE_INT    = 12'h004;
	localparam logic [11:0] OFS_PFLAGS2     = 12'h008;
	localparam logic [11:0] OFS_PENABLES2   = 12'h00C;
	localparam logic [11:0] OFS_PPRIO2      = 12'h010;
	localparam int          BIT_STABLE      = 5;
	localparam int          BIT_POWER_EN    = 4;
	localparam int          LEVEL_LSB       = 0;
	localparam int          LEVEL_W         = 4;
	localparam int          BIT_DROOP       = 2;
	localparam int          BIT_GLOBAL_EN   = 7;
	localparam logic [3:0]  LEVEL_RESET     = 4'h5;
	localparam logic [3:0]  LEVEL_RESERVED  = 4'hF;
	localparam logic [7:0]  LV_CTRL_RESET   = 8'h05;
	localparam logic [7:0]  BYTE_ZERO       = 8'h00;
	localparam logic [31:0] WORD_ZERO       = 32'h0000_0000;
	localparam int          SETTLE_TIME_NS  = 20000;
	localparam int          SETTLE_CYCLES   = (SETTLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int          CNT_W           = 16;
endpackage

// [core/supply_droop_detector.sv]
/*
 Supply droop detector control: control register, droop flag, enable and
 priority bits over APB, settle timing, sleep wake. Assumes an analog
 comparator and reference outside, reporting asynchronously.
*/
// Our own choices: register access over APB and the placing of the registers.
// Operation
// - Detector runs only while power enable is one; otherwise no flag set.
// - Stable flag stays low after each enable until reference has settled.
// - Droop flag never rises from a trip while the stable flag is clear; a software write to flags-two can still set it.
// - Four-bit trip level: 0000 lowest, 1110 highest, 1111 reserved; the code still accepts 1111 and drives it on TRIP_LEVEL_OUT.
// - Comparator trip while enabled and stable sets the droop flag.
// - Droop flag sits in flags-two bit 2 until software clears it.
// - Interrupt request only with local enable and global enable both set.
// - Settle interval is a fixed time, not a clock-speed dependent count; here a fixed count of SETTLE_CYCLES clocks, sized for a 10 MHz clock.
// - Excursions before settling ends may be missed.
// - Detection keeps running in sleep; a trip sets flag, and wakes when the local enable is set.
// - After wake, vector taken only when global interrupts enabled.
// - Reset: enable zero, stable zero, trip level 0101; detector off.
`timescale 1ns/1ps
module supply_droop_detector
	import droop_pkg::*;
(
	input  wire logic        SYS_CLK_IN,
	input  wire logic        RESET_IN,
	input  wire logic        PSEL_IN,
	input  wire logic        PENABLE_IN,
	input  wire logic        PWRITE_IN,
	input  wire logic [11:0] PADDR_IN,
	input  wire logic [31:0] PWDATA_IN,
	input  wire logic [3:0]  PSTRB_IN,
	input  wire logic        TRIP_COMPARE_IN,
	input  wire logic        REF_READY_IN,
	input  wire logic        SLEEP_IN,
	output logic      [31:0] PRDATA_OUT,
	output logic             PREADY_OUT,
	output logic             PSLVERR_OUT,
	output logic             DETECTOR_POWER_OUT,
	output logic      [3:0]  TRIP_LEVEL_OUT,
	output logic             DROOP_IRQ_OUT,
	output logic             DROOP_IRQ_HIGH_OUT,
	output logic             WAKE_OUT,
	output logic             VECTOR_TAKE_OUT
);
	logic [7:0]       ctrl_q, ctrl_d;
	logic [7:0]       core_int_q, core_int_d;
	logic [7:0]       pflags_q, pflags_d;
	logic [7:0]       penables_q, penables_d;
	logic [7:0]       pprio_q, pprio_d;
	logic [CNT_W-1:0] settle_q, settle_d;
	logic             stable_q, stable_d;
	logic [1:0]       trip_sync_q;
	logic [1:0]       ref_sync_q;
	logic [31:0]      rdata_q, rdata_d;
	logic             slverr_q, slverr_d;

	function automatic logic hit(input logic [11:0] a, input logic [11:0] ofs);
		return a == ofs;
	endfunction

	wire logic access   = PSEL_IN && PENABLE_IN;
	wire logic wr       = access && PWRITE_IN && PSTRB_IN[0];
	wire logic sel_ctrl = hit(PADDR_IN, OFS_LV_CTRL);
	wire logic sel_core = hit(PADDR_IN, OFS_CORE_INT);
	wire logic sel_flag = hit(PADDR_IN, OFS_PFLAGS2);
	wire logic sel_en   = hit(PADDR_IN, OFS_PENABLES2);
	wire logic sel_pri  = hit(PADDR_IN, OFS_PPRIO2);
	wire logic mapped   = sel_ctrl | sel_core | sel_flag | sel_en | sel_pri;
	wire logic power_en = ctrl_q[BIT_POWER_EN];
	wire logic trip_s   = trip_sync_q[1];
	wire logic ref_s    = ref_sync_q[1];
	wire logic trip_evt = power_en && stable_q && trip_s;
	wire logic req_loc  = pflags_q[BIT_DROOP] && penables_q[BIT_DROOP];
	wire logic [7:0] ctrl_rd = {2'b00, stable_q, ctrl_q[BIT_POWER_EN], ctrl_q[LEVEL_LSB +: LEVEL_W]};

	always_ff @(posedge SYS_CLK_IN) begin
		if (RESET_IN) begin
			trip_sync_q <= 2'b00;
			ref_sync_q  <= 2'b00;
		end else begin
			trip_sync_q <= {trip_sync_q[0], TRIP_COMPARE_IN};
			ref_sync_q  <= {ref_sync_q[0], REF_READY_IN};
		end
	end

	always_ff @(posedge SYS_CLK_IN) begin
		if (RESET_IN) begin
			ctrl_q     <= LV_CTRL_RESET;
			core_int_q <= BYTE_ZERO;
			pflags_q   <= BYTE_ZERO;
			penables_q <= BYTE_ZERO;
			pprio_q    <= BYTE_ZERO;
			settle_q   <= '0;
			stable_q   <= 1'b0;
			rdata_q    <= WORD_ZERO;
			slverr_q   <= 1'b0;
		end else begin
			ctrl_q     <= ctrl_d;
			core_int_q <= core_int_d;
			pflags_q   <= pflags_d;
			penables_q <= penables_d;
			pprio_q    <= pprio_d;
			settle_q   <= settle_d;
			stable_q   <= stable_d;
			rdata_q    <= rdata_d;
			slverr_q   <= slverr_d;
		end
	end

	always_comb begin
		ctrl_d     = ctrl_q;
		core_int_d = core_int_q;
		penables_d = penables_q;
		pprio_d    = pprio_q;
		pflags_d   = pflags_q;
		// Only enable and level are writable; stable is read-only
		if (wr && sel_ctrl) begin
			ctrl_d = {3'b000, PWDATA_IN[BIT_POWER_EN], PWDATA_IN[LEVEL_LSB +: LEVEL_W]};
		end
		if (wr && sel_core) begin
			core_int_d = PWDATA_IN[7:0];
		end
		if (wr && sel_en) begin
			penables_d = {7'b0000000, PWDATA_IN[BIT_DROOP]} << BIT_DROOP;
		end
		if (wr && sel_pri) begin
			pprio_d = {7'b0000000, PWDATA_IN[BIT_DROOP]} << BIT_DROOP;
		end
		if (wr && sel_flag) begin
			pflags_d[BIT_DROOP] = PWDATA_IN[BIT_DROOP];
		end
		if (trip_evt) begin
			pflags_d[BIT_DROOP] = 1'b1;
		end
	end

	always_comb begin
		settle_d = settle_q;
		stable_d = stable_q;
		if (!power_en) begin
			settle_d = '0;
			stable_d = 1'b0;
		end else if (settle_q < CNT_W'(SETTLE_CYCLES)) begin
			settle_d = settle_q + CNT_W'(1);
		end else if (ref_s) begin
			stable_d = 1'b1;
		end
	end

	always_comb begin
		rdata_d  = rdata_q;
		slverr_d = 1'b0;
		if (PSEL_IN && !PENABLE_IN) begin
			slverr_d = !mapped;
			rdata_d  = WORD_ZERO;
			if (sel_ctrl) rdata_d[7:0] = ctrl_rd;
			if (sel_core) rdata_d[7:0] = core_int_q;
			if (sel_flag) rdata_d[7:0] = pflags_q;
			if (sel_en) rdata_d[7:0] = penables_q;
			if (sel_pri) rdata_d[7:0] = pprio_q;
		end
	end

	assign PRDATA_OUT         = rdata_q;
	assign PREADY_OUT         = 1'b1;
	assign PSLVERR_OUT        = access && slverr_q;
	assign DETECTOR_POWER_OUT = power_en;
	assign TRIP_LEVEL_OUT     = ctrl_q[LEVEL_LSB +: LEVEL_W];
	assign DROOP_IRQ_OUT      = req_loc && core_int_q[BIT_GLOBAL_EN];
	assign DROOP_IRQ_HIGH_OUT = DROOP_IRQ_OUT && pprio_q[BIT_DROOP];
	assign WAKE_OUT           = SLEEP_IN && req_loc;
	assign VECTOR_TAKE_OUT    = WAKE_OUT && core_int_q[BIT_GLOBAL_EN];

	a_flag_needs_stable: assert property (@(posedge SYS_CLK_IN) disable iff (RESET_IN)
		$rose(pflags_q[BIT_DROOP]) |-> $past(stable_q) || $past(wr && sel_flag)) else $error("flag rose unstable");
	a_off_not_stable: assert property (@(posedge SYS_CLK_IN) disable iff (RESET_IN)
		!power_en |=> !stable_q) else $error("stable while off");
	a_settle_wait: assert property (@(posedge SYS_CLK_IN) disable iff (RESET_IN)
		$rose(stable_q) |-> settle_q == CNT_W'(SETTLE_CYCLES)) else $error("stable too early");
	a_trip_sets: assert property (@(posedge SYS_CLK_IN) disable iff (RESET_IN)
		trip_evt |=> pflags_q[BIT_DROOP]) else $error("trip lost");
	a_flag_holds: assert property (@(posedge SYS_CLK_IN) disable iff (RESET_IN)
		pflags_q[BIT_DROOP] && !(wr && sel_flag) |=> pflags_q[BIT_DROOP]) else $error("flag dropped");
	a_irq_gate: assert property (@(posedge SYS_CLK_IN) disable iff (RESET_IN)
		DROOP_IRQ_OUT |-> penables_q[BIT_DROOP] && core_int_q[BIT_GLOBAL_EN]) else $error("irq ungated");
	a_off_no_set: assert property (@(posedge SYS_CLK_IN) disable iff (RESET_IN)
		!power_en && !pflags_q[BIT_DROOP] && !(wr && sel_flag) |=> !pflags_q[BIT_DROOP]) else $error("set while off");
	a_reset_ctrl: assert property (@(posedge SYS_CLK_IN)
		RESET_IN |=> ctrl_q == LV_CTRL_RESET && !stable_q) else $error("bad reset value");
	a_vector_gate: assert property (@(posedge SYS_CLK_IN) disable iff (RESET_IN)
		VECTOR_TAKE_OUT |-> WAKE_OUT && core_int_q[BIT_GLOBAL_EN]) else $error("vector ungated");
	a_wake_sleep: assert property (@(posedge SYS_CLK_IN) disable iff (RESET_IN)
		SLEEP_IN && pflags_q[BIT_DROOP] && penables_q[BIT_DROOP] |-> WAKE_OUT) else $error("no wake");
	c_stable: cover property (@(posedge SYS_CLK_IN) $rose(stable_q));
	c_trip: cover property (@(posedge SYS_CLK_IN) trip_evt);
	c_wake: cover property (@(posedge SYS_CLK_IN) WAKE_OUT);
	c_vector: cover property (@(posedge SYS_CLK_IN) VECTOR_TAKE_OUT);
endmodule // supply_droop_detector

// [verification/supply_droop_detector_tb.sv]
/*
 Self-checking bench for supply_droop_detector with a byte model.
 Assumes a zero-wait APB slave and a settle wait of SETTLE_CYCLES.
*/
`timescale 1ns/1ps
module supply_droop_detector_tb;
	import droop_pkg::*;
	logic        clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0;
	logic        cmp = 0, rdy = 0, slp = 0, err, fl;
	logic [3:0]  stb = 4'hF;
	logic [11:0] pa = 12'h000;
	logic [31:0] pwd = 32'h0, rd, prd, seed = 32'h0000F3AA;
	logic        prdy, perr, pon, irq, irqh, wake, vec;
	logic [3:0]  lvl;
	logic [7:0]  m [5];
	logic [7:0]  msk [5] = '{8'h3F, 8'h80, 8'h04, 8'h04, 8'h04};
	int          n_mismatch = 0, checked = 0, cyc = 0, t0;
	supply_droop_detector dut (.SYS_CLK_IN(clk), .RESET_IN(rst), .PSEL_IN(psel), .PENABLE_IN(pen),
		.PWRITE_IN(pwr), .PADDR_IN(pa), .PWDATA_IN(pwd), .PSTRB_IN(stb), .TRIP_COMPARE_IN(cmp),
		.REF_READY_IN(rdy), .SLEEP_IN(slp), .PRDATA_OUT(prd), .PREADY_OUT(prdy), .PSLVERR_OUT(perr),
		.DETECTOR_POWER_OUT(pon), .TRIP_LEVEL_OUT(lvl), .DROOP_IRQ_OUT(irq),
		.DROOP_IRQ_HIGH_OUT(irqh), .WAKE_OUT(wake), .VECTOR_TAKE_OUT(vec));
	initial forever #50 clk = ~clk;
	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	task automatic conclude();
		$display("checked=%0d n_mismatch=%0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		checked++;
		if (g !== e) begin
			n_mismatch++;
			$display("mismatch t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	// Held request until pready at an edge, then release and idle one cycle
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwr <= w;
		pa <= a;
		pwd <= d;
		@(posedge clk);
		pen <= 1'b1;
		@(posedge clk);
		while (prdy !== 1'b1) @(posedge clk);
		rd = prd;
		err = perr;
		psel <= 1'b0;
		pen <= 1'b0;
		@(posedge clk);
	endtask
	task automatic rdc(input int i);
		apb(1'b0, 12'(i * 4), 32'h0);
		chk(rd & {24'h0, msk[i]}, {24'h0, m[i] & msk[i]});
	endtask
	task automatic wrc(input int i, input logic [7:0] d);
		apb(1'b1, 12'(i * 4), {24'h0, d});
		if (i == 0)
			m[0] = (m[0] & 8'h20) | (d & 8'h1F);
		else
			m[i] = d;
	endtask
	always @(posedge clk) begin
		cyc++;
		if (cyc == 3000) begin
			n_mismatch++;
			conclude();
		end
	end
	initial begin
		m = '{8'h05, 8'h00, 8'h00, 8'h00, 8'h00};
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		for (int i = 0; i < 5; i++) rdc(i);
		chk({28'h0, lvl}, 32'h5);
		for (int i = 0; i < 16; i++) begin
			wrc(0, 8'h20 | 8'(i));
			rdc(0);
			chk({28'h0, lvl}, 32'(i));
		end
		cmp <= 1'b1;
		slp <= 1'b1;
		repeat (6) @(posedge clk);
		rdc(2);
		chk({31'h0, wake}, 32'h0);
		rdy <= 1'b1;
		// level, then enable, then clear stale flag
		wrc(0, 8'h00 | 8'(xs() % 15));
		wrc(0, 8'h10 | m[0]);
		wrc(2, 8'h00);
		t0 = cyc;
		apb(1'b0, OFS_LV_CTRL, 32'h0);
		while (rd[BIT_STABLE] !== 1'b1 && cyc - t0 < 400) begin
			apb(1'b0, OFS_PFLAGS2, 32'h0);
			fl = rd[BIT_DROOP];
			apb(1'b0, OFS_LV_CTRL, 32'h0);
			// Flag read before a still-unstable read must be clear
			if (rd[BIT_STABLE] !== 1'b1) chk({31'h0, fl}, 32'h0);
		end
		chk(32'(cyc - t0 >= SETTLE_CYCLES), 32'h1);
		m[0][5] = 1'b1;
		m[2] = 8'h04;
		// local enable only once stable reads one
		wrc(3, 8'h04);
		repeat (4) @(posedge clk);
		rdc(2);
		chk({30'h0, wake, vec}, 32'h2);
		chk({31'h0, irq}, 32'h0);
		wrc(1, 8'h80);
		chk({30'h0, irq, vec}, 32'h3);
		wrc(4, 8'h04);
		chk({31'h0, irqh}, 32'h1);
		// Write without lane 0 must be ignored
		stb <= 4'h0;
		apb(1'b1, OFS_PPRIO2, 32'h0);
		stb <= 4'hF;
		rdc(4);
		chk({31'h0, irqh}, 32'h1);
		cmp <= 1'b0;
		repeat (4) @(posedge clk);
		rdc(2);
		wrc(2, 8'h00);
		rdc(2);
		chk({31'h0, irq}, 32'h0);
		wrc(0, 8'h03);
		m[0] = 8'h03;
		rdc(0);
		chk({31'h0, pon}, 32'h0);
		apb(1'b0, 12'h014, 32'h0);
		chk({err, rd[30:0]}, 32'h80000000);
		conclude();
	end
endmodule // supply_droop_detector_tb
